// ==== hdl/nfh_pkg.sv ====
// nfh_pkg: constants and types of the nand flash host port controller
// assumes a 50 mhz system clock; every cycle count below is derived from it
package nfh_pkg;

	// ************************************************************
	// clock and widths
	// ************************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int BYTE_W        = 8;
	localparam int FIFO_DEPTH    = 16;
	localparam int CNT_W         = 32;

	// ************************************************************
	// pin timing, least times in ns, rounded up to cycles
	// ************************************************************
	localparam int T_WB_NS   = 100;  // write strobe high to busy valid
	localparam int T_WHR_NS  = 60;   // write strobe high to read strobe low
	localparam int T_RHW_NS  = 30;   // read strobe high to write strobe low
	localparam int WB_CYC    = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WHR_CYC   = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TURN_CYC  = (T_RHW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// busy maxima, longest times rounded down to cycles
	// ************************************************************
	localparam int T_PROG_MAX_US   = 700;
	localparam int T_MPROG_MAX_US  = 700;
	localparam int T_DCBSY_MAX_US  = 1;
	localparam int T_READ_MAX_US   = 220;
	localparam int T_MREAD_MAX_US  = 420;
	localparam int T_RST_MAX_US    = 500;
	localparam int T_ERASE_MAX_MS  = 5;
	localparam int PROG_CYC   = T_PROG_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int MPROG_CYC  = T_MPROG_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int DCBSY_CYC  = T_DCBSY_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int READ_CYC   = T_READ_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int MREAD_CYC  = T_MREAD_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int RST_CYC    = T_RST_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int ERASE_CYC  = T_ERASE_MAX_MS * 1000000 / CLK_PERIOD_NS;

	// ************************************************************
	// command bytes and limits
	// ************************************************************
	localparam logic [7:0] CMD_PROG_CONFIRM  = 8'h10;
	localparam logic [7:0] CMD_MPROG_MID     = 8'h11;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
	localparam logic [7:0] CMD_ECC_STATUS    = 8'h7a;
	localparam logic [7:0] CMD_RESET         = 8'hff;
	localparam logic [2:0] PARTIAL_PROG_MAX  = 3'h4;
	localparam logic [3:0] ECC_SECTORS       = 4'h8;
	localparam logic [2:0] ADDR_CYCLES       = 3'h5;
	localparam logic [2:0] ADDR_PAGE_FIRST   = 3'h2;

	// ************************************************************
	// user operations and busy classes
	// ************************************************************
	typedef enum logic [2:0] {
		OP_CMD   = 3'h0,
		OP_ADDR  = 3'h1,
		OP_WDATA = 3'h2,
		OP_RDATA = 3'h3,
		OP_WAIT  = 3'h4
	} nfh_op_type;

	localparam logic [2:0] WAIT_PROG      = 3'h0;
	localparam logic [2:0] WAIT_MPROG     = 3'h1;
	localparam logic [2:0] WAIT_MPROG_MID = 3'h2;
	localparam logic [2:0] WAIT_READ      = 3'h3;
	localparam logic [2:0] WAIT_MREAD     = 3'h4;
	localparam logic [2:0] WAIT_RESET     = 3'h5;
	localparam logic [2:0] WAIT_ERASE     = 3'h6;

endpackage

// ==== hdl/nfh_fifo.sv ====
// nfh_fifo: valid/ready fifo for the bytes headed to the flash
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none

module nfh_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output var  logic             in_ready,
	output var  logic             out_valid,
	output var  logic [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             pop;

	// handshakes on both sides
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_valid = (count_reg != '0);
	assign out_data  = mem[rd_ptr_reg];

	// occupancy after this cycle
	always_comb begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	// storage
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
	end

	// pointers, count and registered ready
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			in_ready   <= 1'b0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_next;
			in_ready  <= (count_next != (AW+1)'(DEPTH)); // full stalls the source
		end
	end

endmodule // nfh_fifo

`default_nettype wire

// ==== hdl/nfh_host.sv ====
// nfh_host: host-side sequencer that drives a nand flash byte port
// assumes pins synchronous to clk; ready_busy_n has an external pull-up
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// R1: command byte written with cle high
// R2: device drives bus from strobe fall
// R3: device may drive until ce rises
// R4: at most four programs per page; code counts them on the last programmed page only
// R5: ecc status read fetches eight bytes
// R6: ecc status only right after ready
// R7: never drive while device may drive
// R8: reset wait bounded at 500 us
// R9: single program wait bounded 700 us
// R10: multi program wait bounded 700 us
// R11: intermediate program busy bounded 1 us
// R12: single page read bounded 220 us
// R13: multi page read bounded 420 us
// R14: address byte written with ale high
// R15: one byte per read strobe fall
// R16: busy low while operation runs
// R17: timeout on busy marks device failed
module nfh_host #(
	parameter int PROG_CYC_P  = nfh_pkg::PROG_CYC,
	parameter int MPROG_CYC_P = nfh_pkg::MPROG_CYC,
	parameter int READ_CYC_P  = nfh_pkg::READ_CYC,
	parameter int MREAD_CYC_P = nfh_pkg::MREAD_CYC,
	parameter int RST_CYC_P   = nfh_pkg::RST_CYC,
	parameter int ERASE_CYC_P = nfh_pkg::ERASE_CYC
) (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic                       cmd_valid,
	input  wire nfh_pkg::nfh_op_type        cmd_op,
	input  wire logic [nfh_pkg::BYTE_W-1:0] cmd_arg,
	output var  logic                       cmd_ready,
	input  wire logic                       wr_valid,
	input  wire logic [nfh_pkg::BYTE_W-1:0] wr_data,
	output var  logic                       wr_ready,
	output var  logic                       rd_valid,
	output var  logic [nfh_pkg::BYTE_W-1:0] rd_data,
	output var  logic                       op_done,
	output var  logic                       op_refused,
	output var  logic                       op_timeout,
	output var  logic                       dev_failed,
	output var  logic                       nand_ce_n,
	output var  logic                       nand_cle,
	output var  logic                       nand_ale,
	output var  logic                       nand_we_n,
	output var  logic                       read_strobe_n,
	output var  logic                       nand_wp_n,
	input  wire logic                       ready_busy_n,
	input  wire logic [nfh_pkg::BYTE_W-1:0] bus_in,
	output var  logic [nfh_pkg::BYTE_W-1:0] bus_out,
	output var  logic                       bus_oe
);
	import nfh_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE     = 4'h0,
		ST_TURN     = 4'h1,
		ST_FETCH    = 4'h2,
		ST_WR_SETUP = 4'h3,
		ST_WR_LOW   = 4'h4,
		ST_WR_HIGH  = 4'h5,
		ST_WR_HOLD  = 4'h6,
		ST_RD_GAP   = 4'h7,
		ST_RD_LOW   = 4'h8,
		ST_RD_WAIT  = 4'h9,
		ST_RD_HIGH  = 4'ha,
		ST_WAIT_WB  = 4'hb,
		ST_WAIT_RDY = 4'hc
	} nfh_state_type;

	nfh_state_type       state_reg;
	nfh_op_type          op_reg;
	logic [BYTE_W-1:0]   arg_reg;
	logic [BYTE_W-1:0]   wbyte_reg;
	logic [CNT_W-1:0]    cnt_reg;
	logic [CNT_W-1:0]    limit_reg;
	logic [3:0]          ecc_left_reg;
	logic                dev_drives_reg;
	logic [2:0]          addr_idx_reg;
	logic [23:0]         page_cur_reg;
	logic [23:0]         page_last_reg;
	logic [2:0]          prog_cnt_reg;
	logic                ecc_win_reg;
	logic                fifo_valid;
	logic [BYTE_W-1:0]   fifo_data;
	logic                fifo_pop;
	logic                commit;
	logic                ready_seen;
	logic                prog_limit_hit;
	logic                reject;

	// busy limit in cycles for each wait class
	function automatic logic [CNT_W-1:0] busy_limit(input logic [2:0] cls);
		case (cls)
			WAIT_PROG:      busy_limit = CNT_W'(PROG_CYC_P);   // R9
			WAIT_MPROG:     busy_limit = CNT_W'(MPROG_CYC_P);  // R10
			WAIT_MPROG_MID: busy_limit = CNT_W'(DCBSY_CYC);    // R11
			WAIT_READ:      busy_limit = CNT_W'(READ_CYC_P);   // R12
			WAIT_MREAD:     busy_limit = CNT_W'(MREAD_CYC_P);  // R13
			WAIT_RESET:     busy_limit = CNT_W'(RST_CYC_P);    // R8
			default:        busy_limit = CNT_W'(ERASE_CYC_P);
		endcase
	endfunction

	// ************************************************************
	// write data buffer
	// ************************************************************
	nfh_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.in_valid  (wr_valid),
		.in_data   (wr_data),
		.in_ready  (wr_ready),
		.out_valid (fifo_valid),
		.out_data  (fifo_data),
		.out_ready (fifo_pop)
	);

	// ************************************************************
	// events and admission checks
	// ************************************************************
	assign fifo_pop       = (state_reg == ST_FETCH) && fifo_valid;
	assign commit         = (state_reg == ST_WR_HOLD);
	assign ready_seen     = (state_reg == ST_WAIT_RDY) && ready_busy_n; // R16
	assign prog_limit_hit = (page_cur_reg == page_last_reg)
	                        && (prog_cnt_reg == PARTIAL_PROG_MAX);
	always_comb begin
		reject = 1'b0;
		if (dev_failed && !(cmd_op == OP_CMD && cmd_arg == CMD_RESET))
			reject = 1'b1; // R17
		if (cmd_op == OP_CMD && cmd_arg == CMD_ECC_STATUS && !ecc_win_reg)
			reject = 1'b1; // R6
		if (cmd_op == OP_CMD && (cmd_arg == CMD_PROG_CONFIRM || cmd_arg == CMD_MPROG_MID)
		    && prog_limit_hit)
			reject = 1'b1; // R4
	end

	// ************************************************************
	// sequencer and pin drive
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg      <= ST_IDLE;
			op_reg         <= OP_CMD;
			arg_reg        <= '0;
			wbyte_reg      <= '0;
			cnt_reg        <= '0;
			limit_reg      <= '0;
			ecc_left_reg   <= '0;
			dev_drives_reg <= 1'b0;
			cmd_ready      <= 1'b0;
			rd_valid       <= 1'b0;
			rd_data        <= '0;
			op_done        <= 1'b0;
			op_refused     <= 1'b0;
			op_timeout     <= 1'b0;
			nand_ce_n      <= 1'b1;
			nand_cle       <= 1'b0;
			nand_ale       <= 1'b0;
			nand_we_n      <= 1'b1;
			read_strobe_n  <= 1'b1;
			nand_wp_n      <= 1'b1;
			bus_out        <= '0;
			bus_oe         <= 1'b0;
		end else begin
			rd_valid   <= 1'b0;
			op_done    <= 1'b0;
			op_refused <= 1'b0;
			op_timeout <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						op_reg    <= cmd_op;
						arg_reg   <= cmd_arg;
						wbyte_reg <= cmd_arg;
						cnt_reg   <= '0;
						limit_reg <= busy_limit(cmd_arg[2:0]);
						if (reject) begin
							op_refused <= 1'b1;
							op_done    <= 1'b1;
						end else if (cmd_op == OP_WAIT)
							state_reg <= ST_WAIT_WB;
						else if (cmd_op == OP_RDATA)
							state_reg <= ST_RD_GAP;
						else if (dev_drives_reg)
							state_reg <= ST_TURN; // R7
						else if (cmd_op == OP_WDATA)
							state_reg <= ST_FETCH;
						else
							state_reg <= ST_WR_SETUP;
					end
				end
				ST_TURN: begin
					nand_ce_n <= 1'b1; // R3
					cnt_reg   <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(TURN_CYC - 1)) begin
						dev_drives_reg <= 1'b0; // R7
						cnt_reg        <= '0;
						state_reg      <= (op_reg == OP_WDATA) ? ST_FETCH : ST_WR_SETUP;
					end
				end
				ST_FETCH: begin
					if (fifo_valid) begin
						wbyte_reg <= fifo_data;
						state_reg <= ST_WR_SETUP;
					end
				end
				ST_WR_SETUP: begin
					nand_ce_n <= 1'b0;
					nand_cle  <= (op_reg == OP_CMD);  // R1
					nand_ale  <= (op_reg == OP_ADDR); // R14
					bus_out   <= wbyte_reg;
					bus_oe    <= 1'b1;
					state_reg <= ST_WR_LOW;
				end
				ST_WR_LOW: begin
					nand_we_n <= 1'b0;
					state_reg <= ST_WR_HIGH;
				end
				ST_WR_HIGH: begin
					nand_we_n <= 1'b1; // latching edge
					state_reg <= ST_WR_HOLD;
				end
				ST_WR_HOLD: begin
					nand_cle <= 1'b0;
					nand_ale <= 1'b0;
					bus_oe   <= 1'b0;
					if (op_reg == OP_CMD && wbyte_reg == CMD_ECC_STATUS) begin
						ecc_left_reg <= ECC_SECTORS; // R5
						cnt_reg      <= '0;
						state_reg    <= ST_RD_GAP;
					end else begin
						op_done   <= 1'b1;
						state_reg <= ST_IDLE;
					end
				end
				ST_RD_GAP: begin
					nand_ce_n <= 1'b0;
					cnt_reg   <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(WHR_CYC - 1)) begin
						cnt_reg   <= '0;
						state_reg <= ST_RD_LOW;
					end
				end
				ST_RD_LOW: begin
					read_strobe_n  <= 1'b0; // R15
					dev_drives_reg <= 1'b1; // R2
					state_reg      <= ST_RD_WAIT;
				end
				ST_RD_WAIT: state_reg <= ST_RD_HIGH;
				ST_RD_HIGH: begin
					read_strobe_n <= 1'b1;
					rd_data       <= bus_in; // R15
					rd_valid      <= 1'b1;
					if (ecc_left_reg > 4'h1) begin
						ecc_left_reg <= ecc_left_reg - 1'b1; // R5
						state_reg    <= ST_RD_LOW;
					end else begin
						ecc_left_reg <= '0;
						op_done      <= 1'b1;
						state_reg    <= ST_IDLE;
					end
				end
				ST_WAIT_WB: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (cnt_reg == CNT_W'(WB_CYC - 1)) begin
						cnt_reg   <= '0;
						state_reg <= ST_WAIT_RDY;
					end
				end
				ST_WAIT_RDY: begin
					cnt_reg <= cnt_reg + 1'b1;
					if (ready_busy_n) begin // R16
						op_done   <= 1'b1;
						state_reg <= ST_IDLE;
					end else if (cnt_reg >= limit_reg) begin
						op_timeout <= 1'b1; // R17
						op_done    <= 1'b1;
						state_reg  <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ************************************************************
	// page tracking for partial programs
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_idx_reg  <= '0;
			page_cur_reg  <= '0;
			page_last_reg <= '1;
			prog_cnt_reg  <= '0;
		end else if (commit && op_reg == OP_CMD) begin
			addr_idx_reg <= '0;
			if (wbyte_reg == CMD_PROG_CONFIRM || wbyte_reg == CMD_MPROG_MID) begin
				page_last_reg <= page_cur_reg;
				prog_cnt_reg  <= (page_cur_reg == page_last_reg) ?
				                 prog_cnt_reg + 1'b1 : 3'h1; // R4
			end else if (wbyte_reg == CMD_ERASE_CONFIRM)
				prog_cnt_reg <= '0; // erase restarts the count
		end else if (commit && op_reg == OP_ADDR) begin
			case (addr_idx_reg - ADDR_PAGE_FIRST)
				3'h0:    page_cur_reg[7:0]   <= wbyte_reg;
				3'h1:    page_cur_reg[15:8]  <= wbyte_reg;
				3'h2:    page_cur_reg[23:16] <= wbyte_reg;
				default: page_cur_reg        <= page_cur_reg;
			endcase
			if (addr_idx_reg != ADDR_CYCLES)
				addr_idx_reg <= addr_idx_reg + 1'b1;
		end
	end

	// ************************************************************
	// ecc status window and failure flag
	// ************************************************************
	always_ff @(posedge clk) begin
		if (sys_rst)
			ecc_win_reg <= 1'b0;
		else if (ready_seen)
			ecc_win_reg <= 1'b1; // R6
		else if ((commit && op_reg == OP_CMD) || state_reg == ST_RD_LOW)
			ecc_win_reg <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			dev_failed <= 1'b0;
		else if (state_reg == ST_WAIT_RDY && !ready_busy_n && cnt_reg >= limit_reg)
			dev_failed <= 1'b1; // R17
		else if (commit && op_reg == OP_CMD && wbyte_reg == CMD_RESET)
			dev_failed <= 1'b0;
	end

endmodule // nfh_host

`default_nettype wire

// ==== dv/nfh_checker.sv ====
// nfh_checker: concurrent checks on the pins of the flash host port
// assumes it is bound onto nfh_host; one clock, synchronous reset
`timescale 1ns/10ps
`default_nettype none

module nfh_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic op_done,
	input wire logic op_refused,
	input wire logic op_timeout,
	input wire logic dev_failed,
	input wire logic rd_valid,
	input wire logic nand_ce_n,
	input wire logic nand_cle,
	input wire logic nand_ale,
	input wire logic nand_we_n,
	input wire logic read_strobe_n,
	input wire logic ready_busy_n,
	input wire logic bus_oe
);
	// ************************************************************
	// pin relations
	// ************************************************************
	logic edo_hold_reg;

	// device may keep driving after a read until chip select goes high
	always_ff @(posedge clk) begin
		if (sys_rst)
			edo_hold_reg <= 1'b0;
		else if (!read_strobe_n)
			edo_hold_reg <= 1'b1;
		else if (nand_ce_n)
			edo_hold_reg <= 1'b0;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	cmd_latch_a: assert property ($rose(nand_we_n) && nand_cle |-> !nand_ale && bus_oe && !nand_ce_n)
		else $error("command byte latched without a clean command cycle");
	addr_latch_a: assert property ($rose(nand_we_n) && nand_ale |-> !nand_cle && bus_oe && !nand_ce_n)
		else $error("address byte latched without a clean address cycle");
	no_contention_a: assert property (!read_strobe_n |-> !bus_oe)
		else $error("host drives the bus while the read strobe is low");
	edo_release_a: assert property (bus_oe |-> !edo_hold_reg)
		else $error("host drives before the device was deselected");
	read_byte_a: assert property (rd_valid |-> $rose(read_strobe_n) && !nand_ce_n)
		else $error("read byte delivered without a read strobe");
	refuse_quiet_a: assert property (op_refused |-> op_done && nand_we_n && read_strobe_n)
		else $error("refusal without done or with strobe activity");
	timeout_fail_a: assert property (op_timeout |-> !ready_busy_n ##[0:1] dev_failed)
		else $error("busy overrun did not mark the device failed");
	failed_cause_a: assert property ($rose(dev_failed) |-> op_timeout || $past(op_timeout))
		else $error("device failed without a busy overrun");
	busy_quiet_a: assert property (!ready_busy_n |-> nand_we_n && read_strobe_n)
		else $error("strobe toggled while the device is busy");
endmodule // nfh_checker

bind nfh_host nfh_checker nfh_checker_inst (.clk, .sys_rst, .op_done, .op_refused, .op_timeout,
	.dev_failed, .rd_valid, .nand_ce_n, .nand_cle, .nand_ale, .nand_we_n, .read_strobe_n,
	.ready_busy_n, .bus_oe);

`default_nettype wire

// ==== dv/nfh_flash_model.sv ====
// nfh_flash_model: behavioural nand flash byte port, clockless
// assumes the bench resolves the shared byte bus and feeds it back in
`timescale 1ns/10ps
`default_nettype none

module nfh_flash_model (
	input  wire logic        ce_n,
	input  wire logic        cle,
	input  wire logic        ale,
	input  wire logic        we_n,
	input  wire logic        re_n,
	input  wire logic [7:0]  bus,
	input  wire logic [15:0] busy_ns,
	output var  logic        busy_n,
	output var  logic [7:0]  dq,
	output var  logic        dq_oe
);
	// ************************************************************
	// device behaviour
	// ************************************************************
	logic [7:0]  cmd_reg;
	logic [12:0] col;
	logic [23:0] row;
	logic [2:0]  acnt;
	logic        ecc_mode;
	logic [7:0]  mem [0:31];
	localparam int REH_LONG_NS = 100; // strobe-high time taken as long

	initial begin
		{busy_n, dq, dq_oe, cmd_reg, col, row, acnt, ecc_mode} = {1'b1, 58'h0};
	end

	// normal read: a long strobe-high time turns the drivers off
	always @(posedge re_n) begin
		#(REH_LONG_NS);
		if (re_n)
			dq_oe = 1'b0;
	end

	// latch command, address or data on the rising write strobe
	always @(posedge we_n) begin
		if (!ce_n && cle) begin
			cmd_reg = bus;
			acnt = 3'h0;
			ecc_mode = (bus == 8'h7a);
			if (ecc_mode)
				col = 13'h0;
			case (bus)
				8'h10, 8'h30, 8'hd0: begin
					busy_n = 1'b0;
					busy_n <= #(busy_ns) 1'b1;
				end
				8'h11: begin
					busy_n = 1'b0;
					busy_n <= #500 1'b1;
				end
				8'hff: begin
					busy_n = 1'b0;
					busy_n <= #300 1'b1;
				end
				default: ;
			endcase
		end else if (!ce_n && ale) begin
			case (acnt)
				3'h0: col[7:0] = bus;
				3'h1: col[12:8] = bus[4:0];
				3'h2: row[7:0] = bus;
				3'h3: row[15:8] = bus;
				default: row[23:16] = bus;
			endcase
			acnt = acnt + 3'h1;
		end else if (!ce_n) begin
			mem[col[4:0]] = bus;
			col = col + 13'h1;
		end
	end

	// present the next byte, then step the column
	always @(negedge re_n) begin
		if (!ce_n) begin
			dq = ecc_mode ? (8'h80 | {5'h0, col[2:0]}) : (col[7:0] ^ 8'h5a);
			dq_oe = 1'b1;
			col = col + 13'h1;
		end
	end

	// extended output: strobe rise keeps driving, these edges release
	always @(posedge ce_n or posedge cle or posedge ale or negedge we_n) begin
		dq_oe = 1'b0;
	end
endmodule // nfh_flash_model

`default_nettype wire

// ==== dv/nfh_host_tb.sv ====
// nfh_host_tb: self-checking bench of the flash host port controller
// assumes nfh_pkg, nfh_host, nfh_fifo, the flash model and checker
`timescale 1ns/10ps
`default_nettype none

module nfh_host_tb;
	import nfh_pkg::*;
	// ************************************************************
	// bench
	// ************************************************************
	localparam int LIMIT = 30000;
	logic clk, sys_rst, cmd_valid, cmd_ready, wr_valid, wr_ready, rd_valid, op_done;
	logic op_refused, op_timeout, dev_failed, nand_ce_n, nand_cle, nand_ale, nand_we_n;
	logic read_strobe_n, nand_wp_n, ready_busy_n, bus_oe, dq_oe, got_ref, got_to;
	nfh_op_type  cmd_op;
	logic [7:0]  cmd_arg, wr_data, rd_data, bus_in, bus_out, dq;
	logic [15:0] busy_ns;
	logic [23:0] row_a;
	logic [31:0] seed;
	logic [7:0]  rdq [$];
	logic [7:0]  wq [$];
	int          failures, n_compared, cycles, n;

	// shared bus: device, else host, else the inverse of the last byte
	assign bus_in = dq_oe ? dq : (bus_oe ? bus_out : ~dq);

	nfh_host #(.PROG_CYC_P(100), .MPROG_CYC_P(100), .READ_CYC_P(60), .MREAD_CYC_P(80),
		.ERASE_CYC_P(200)) nfh_host_inst (.clk, .sys_rst, .cmd_valid,
		.cmd_op, .cmd_arg, .cmd_ready, .wr_valid, .wr_data, .wr_ready, .rd_valid, .rd_data,
		.op_done, .op_refused, .op_timeout, .dev_failed, .nand_ce_n, .nand_cle, .nand_ale,
		.nand_we_n, .read_strobe_n, .nand_wp_n, .ready_busy_n, .bus_in, .bus_out, .bus_oe);

	nfh_flash_model nfh_flash_model_inst (.ce_n(nand_ce_n), .cle(nand_cle), .ale(nand_ale),
		.we_n(nand_we_n), .re_n(read_strobe_n), .bus(bus_in), .busy_ns(busy_ns),
		.busy_n(ready_busy_n), .dq(dq), .dq_oe(dq_oe));

	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction

	function automatic logic [7:0] exp_data(input int c);
		return 8'(c) ^ 8'h5a;
	endfunction

	task automatic complete_run();
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_flag(input logic got, input logic exp);
		chk_byte({7'h0, got}, {7'h0, exp});
	endtask

	// one request on the command port, then wait for its end
	task automatic op(input nfh_op_type o, input logic [7:0] a);
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_arg = a;
		while (cmd_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		cmd_valid = 1'b0;
		while (op_done !== 1'b1) @(negedge clk);
		#1; // let the byte collector take the last byte first
		got_ref = op_refused;
		got_to = op_timeout;
	endtask

	task automatic wt(input logic [2:0] cls, input logic to_exp);
		op(OP_WAIT, {5'h0, cls});
		chk_flag(got_to, to_exp);
	endtask

	task automatic addr5(input logic [23:0] row);
		op(OP_ADDR, 8'h00);
		op(OP_ADDR, 8'h00);
		op(OP_ADDR, row[7:0]);
		op(OP_ADDR, row[15:8]);
		op(OP_ADDR, row[23:16]);
	endtask

	task automatic prog(input logic [23:0] row, input int nb, input logic [7:0] conf,
		input logic [2:0] cls, input logic ref_exp, input logic to_exp);
		op(OP_CMD, 8'h80);
		addr5(row);
		repeat (nb) op(OP_WDATA, 8'h00);
		op(OP_CMD, conf);
		chk_flag(got_ref, ref_exp);
		if (!got_ref)
			wt(cls, to_exp);
	endtask

	task automatic rdpage(input logic [2:0] cls);
		op(OP_CMD, 8'h00);
		addr5(row_a);
		op(OP_CMD, 8'h30);
		wt(cls, 1'b0);
		rdq.delete();
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles >= LIMIT) begin
			failures++;
			complete_run();
		end
	end

	// collect delivered read bytes
	always @(negedge clk) begin
		if (rd_valid === 1'b1)
			rdq.push_back(rd_data);
	end

	initial begin
		{sys_rst, cmd_valid, cmd_arg, wr_valid, wr_data} = {1'b1, 18'h0};
		cmd_op = OP_CMD;
		{failures, n_compared, cycles, n} = 128'h0;
		busy_ns = 16'd600;
		seed = 32'h8416;
		repeat (4) @(negedge clk);
		sys_rst = 1'b0;
		row_a = {8'h00, rnd(), rnd()};
		// fill the fifo until it refuses
		@(negedge clk);
		while (wr_ready === 1'b1 && n < 20) begin
			wr_valid = 1'b1;
			wr_data = rnd();
			wq.push_back(wr_data);
			n++;
			@(negedge clk);
		end
		wr_valid = 1'b0;
		chk_byte(8'(n), 8'(FIFO_DEPTH));
		prog(row_a, 16, CMD_PROG_CONFIRM, WAIT_PROG, 1'b0, 1'b0);
		for (int i = 0; i < 16; i++)
			chk_byte(nfh_flash_model_inst.mem[i], wq[i]);
		chk_byte(nfh_flash_model_inst.cmd_reg, CMD_PROG_CONFIRM);
		chk_flag(nand_wp_n, 1'b1);
		chk_byte(nfh_flash_model_inst.row[7:0], row_a[7:0]);
		chk_byte(nfh_flash_model_inst.row[15:8], row_a[15:8]);
		// partial programs up to the limit, then refusals
		repeat (3) prog(row_a, 0, CMD_PROG_CONFIRM, WAIT_PROG, 1'b0, 1'b0);
		prog(row_a, 0, CMD_PROG_CONFIRM, WAIT_PROG, 1'b1, 1'b0);
		prog(row_a, 0, CMD_MPROG_MID, WAIT_MPROG_MID, 1'b1, 1'b0);
		// erase clears the count; multi page program follows
		op(OP_CMD, 8'h60);
		op(OP_ADDR, row_a[7:0]);
		op(OP_ADDR, row_a[15:8]);
		op(OP_ADDR, 8'h00);
		op(OP_CMD, CMD_ERASE_CONFIRM);
		wt(WAIT_ERASE, 1'b0);
		prog(row_a, 0, CMD_MPROG_MID, WAIT_MPROG_MID, 1'b0, 1'b0);
		prog(row_a, 0, CMD_PROG_CONFIRM, WAIT_MPROG, 1'b0, 1'b0);
		// ecc status right after ready: eight sector bytes
		rdpage(WAIT_READ);
		op(OP_CMD, CMD_ECC_STATUS);
		chk_flag(got_ref, 1'b0);
		chk_byte(8'(rdq.size()), 8'(ECC_SECTORS));
		for (int i = 0; i < 8; i++)
			chk_byte(rdq[i], 8'h80 | 8'(i));
		// data bytes one per strobe, then ecc status is refused
		rdpage(WAIT_MREAD);
		repeat (4) op(OP_RDATA, 8'h00);
		for (int i = 0; i < 4; i++)
			chk_byte(rdq[i], exp_data(i));
		op(OP_CMD, CMD_ECC_STATUS);
		chk_flag(got_ref, 1'b1);
		// busy overrun, refusal while failed, reset recovers
		busy_ns = 16'd4000;
		prog(row_a, 0, CMD_PROG_CONFIRM, WAIT_PROG, 1'b0, 1'b1);
		chk_flag(dev_failed, 1'b1);
		op(OP_CMD, 8'h00);
		chk_flag(got_ref, 1'b1);
		n = 0;
		while (ready_busy_n !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		busy_ns = 16'd600;
		op(OP_CMD, CMD_RESET);
		wt(WAIT_RESET, 1'b0);
		chk_flag(dev_failed, 1'b0);
		complete_run();
	end
endmodule // nfh_host_tb

`default_nettype wire
